// [src/vpl_position_limits.sv]
// Command conditioning, soft limits, travel and cycle monitoring with APB registers
// Overview of operation
// R1 - Stem follows command above cutoff; at or below it the actuator saturates.
// R2 - Saturation persists until the rising command reaches cutoff plus hysteresis.
// R3 - Cutoff acts only when lower soft limit is at or below zero.
// R4 - Cutoff is disabled whenever soft travel stops are active.
// R5 - Target position is clamped between lower and upper soft limits.
// R6 - Command beyond a soft limit holds at the limit and blinks yellow.
// R7 - After reset, dead-band thresholds are centred on the first position.
// R8 - Leaving dead-band adds distance from centre, then recentres thresholds.
// R9 - Travel dead-band defaults to twenty percent of stroke.
// R10 - Position strictly inside the dead-band adds nothing to travel.
// R11 - Movement is scaled by stroke length; full stroke adds one length.
// R12 - Stroke length serves travel accounting only, never calibration.
// R13 - Cycle counts only on reversal beyond the cycle dead-band.
// R14 - Cycle count above the configured limit blinks yellow.
// R15 - Deviation above trip for longer than settling time blinks yellow; the code ignores deviation while the drive is saturated.
// R16 - Curve edits are accepted only while out of service.
// R17 - Feature byte bits decode by position, custom curve bit selects curve.
// R18 - Curves hold 21 points, range -10 to 110, non-decreasing.
// R19 - Host must not set factory curve flags while editing a curve.
// R20 - A fixed one percent hysteresis is added to the cutoff.
// R21 - Travel total and cycle count only increase and saturate.
`timescale 1ns/1ps
`default_nettype none
module vpl_position_limits
	import vpl_pkg::*;
#(
	parameter int BLINK_CYCLES = BLINK_CYC,
	parameter int DEV_TIME_RST = DEV_TIME_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Stem feedback and actuator drive
	input wire vpl_pos_t stemPos,
	output vpl_drive_t drive,
	// Indicator
	output logic yellowLed
);
	// Configuration and state
	logic signed [15:0] cmd_r, cutoff_r, softLo_r, softHi_r, travelDb_r, cycleDb_r, devTrip_r;
	logic [15:0] stroke_r;
	logic [31:0] cycleLim_r, devTime_r, travel_r, cycles_r, devCnt_r, blinkCnt_r, prdata_r;
	vpl_mode_t mode_r;
	logic [7:0] features_r;
	logic sat_r, editRefused_r, pslverr_r, blink_r;
	logic signed [15:0] curve_x_points_r [CURVE_PTS];
	logic signed [15:0] curve_y_points_r [CURVE_PTS];
	logic signed [15:0] center_r, extreme_r, lastPos_r;
	logic posSeen_r, dirUp_r;
	vpl_drive_t drive_r;

	// Curve address decode: hit flag, axis and point index
	function automatic logic [6:0] curveDecode(input logic [11:0] a);
		logic hit;
		logic [4:0] idx;
		hit = 1'b0;
		idx = a[6:2];
		if ((a[11:7] == OFS_CURVE_X[11:7] || a[11:7] == OFS_CURVE_Y[11:7]) && a[1:0] == 2'b00
			&& idx < 5'(CURVE_PTS)) begin
			hit = 1'b1;
		end
		return {hit, a[7], idx};
	endfunction : curveDecode

	function automatic logic signed [15:0] clampPos(input logic signed [15:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : clampPos

	// Bus phases: data is captured in setup, answered in access with no wait state
	logic setupPh, accessWr;
	logic [6:0] cdec;
	logic [4:0] cIdx;
	logic cHit, cIsY;
	assign setupPh = psel & ~penable;
	assign accessWr = psel & penable & pwrite;
	assign cdec = curveDecode(paddr);
	assign cHit = cdec[6];
	assign cIsY = cdec[5];
	assign cIdx = cdec[4:0];
	assign pready = psel & penable;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r & psel & penable;

	// Curve edit acceptance
	logic signed [15:0] wVal, prevPt;
	logic editOk, editInRange, editOrdered, factorySel;
	assign wVal = pwdata[15:0];
	assign prevPt = (cIdx == 5'd0) ? POS_MIN : (cIsY ? curve_y_points_r[cIdx - 5'd1] : curve_x_points_r[cIdx - 5'd1]);
	assign editInRange = (wVal >= POS_MIN) && (wVal <= POS_MAX); // R18
	assign editOrdered = (wVal >= prevPt); // R18
	assign factorySel = features_r[FEAT_QUICK_OPEN] | features_r[FEAT_EQUAL_PCT]; // R19
	assign editOk = (mode_r == OPM_OUT_OF_SERVICE) && !factorySel && editInRange && editOrdered; // R16

	// Plain register decode
	logic mapped;
	always_comb begin
		if (cHit) begin
			mapped = 1'b1;
		end else if (paddr == OFS_CMD || paddr == OFS_CUTOFF || paddr == OFS_SOFT_LO
			|| paddr == OFS_SOFT_HI || paddr == OFS_TRAVEL_DB || paddr == OFS_STROKE
			|| paddr == OFS_TRAVEL || paddr == OFS_CYCLE_DB || paddr == OFS_CYCLES
			|| paddr == OFS_CYCLE_LIM || paddr == OFS_DEV_TRIP || paddr == OFS_DEV_TIME
			|| paddr == OFS_MODE || paddr == OFS_FEATURES || paddr == OFS_STATUS) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// Soft limit clamp and cutoff qualification
	logic signed [15:0] clampedCmd;
	logic limitHold, softActive, cutoffEn, cycleAlert, devAlert;
	assign clampedCmd = clampPos(cmd_r, softLo_r, softHi_r); // R5
	assign limitHold = (cmd_r < softLo_r) || (cmd_r > softHi_r); // R6
	assign softActive = (softLo_r > 16'sh0000) || (softHi_r < POS_FULL); // R4
	assign cutoffEn = (cutoff_r > 16'sh0000) && (softLo_r <= 16'sh0000) && !softActive; // R3 R4

	// Status word
	logic [31:0] statusWord;
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[ST_SATURATED] = sat_r;
		statusWord[ST_LIMIT_HOLD] = limitHold;
		statusWord[ST_CYCLE_ALERT] = cycleAlert;
		statusWord[ST_DEV_ALERT] = devAlert;
		statusWord[ST_EDIT_REFUSED] = editRefused_r;
		statusWord[ST_CURVE_ACTIVE] = features_r[FEAT_CUSTOM_CURVE]; // R17
	end

	// Read data and error captured in the setup cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setupPh) begin
			pslverr_r <= !mapped || (pwrite && cHit && !editOk);
			prdata_r <= 32'h0000_0000;
			if (!pwrite) begin
				if (cHit) begin
					prdata_r <= {{16{1'b0}}, cIsY ? curve_y_points_r[cIdx] : curve_x_points_r[cIdx]};
				end else if (paddr == OFS_CMD) begin
					prdata_r <= {16'h0000, cmd_r};
				end else if (paddr == OFS_CUTOFF) begin
					prdata_r <= {16'h0000, cutoff_r};
				end else if (paddr == OFS_SOFT_LO) begin
					prdata_r <= {16'h0000, softLo_r};
				end else if (paddr == OFS_SOFT_HI) begin
					prdata_r <= {16'h0000, softHi_r};
				end else if (paddr == OFS_TRAVEL_DB) begin
					prdata_r <= {16'h0000, travelDb_r};
				end else if (paddr == OFS_STROKE) begin
					prdata_r <= {16'h0000, stroke_r};
				end else if (paddr == OFS_TRAVEL) begin
					prdata_r <= travel_r;
				end else if (paddr == OFS_CYCLE_DB) begin
					prdata_r <= {16'h0000, cycleDb_r};
				end else if (paddr == OFS_CYCLES) begin
					prdata_r <= cycles_r;
				end else if (paddr == OFS_CYCLE_LIM) begin
					prdata_r <= cycleLim_r;
				end else if (paddr == OFS_DEV_TRIP) begin
					prdata_r <= {16'h0000, devTrip_r};
				end else if (paddr == OFS_DEV_TIME) begin
					prdata_r <= devTime_r;
				end else if (paddr == OFS_MODE) begin
					prdata_r <= {31'h0000_0000, mode_r};
				end else if (paddr == OFS_FEATURES) begin
					prdata_r <= {24'h00_0000, features_r};
				end else if (paddr == OFS_STATUS) begin
					prdata_r <= statusWord;
				end
			end
		end
	end

	// Configuration writes need the low two byte strobes; cycle limit and deviation time need all four
	logic wrOk;
	assign wrOk = accessWr && (pstrb[1:0] == 2'b11);
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_r <= 16'sh0000;
			cutoff_r <= RST_CUTOFF;
			softLo_r <= RST_SOFT_LO;
			softHi_r <= RST_SOFT_HI;
			travelDb_r <= RST_TRAVEL_DB; // R9
			stroke_r <= RST_STROKE;
			cycleDb_r <= RST_CYCLE_DB;
			cycleLim_r <= RST_CYCLE_LIM;
			devTrip_r <= RST_DEV_TRIP;
			devTime_r <= 32'(DEV_TIME_RST);
			mode_r <= OPM_AUTO;
			features_r <= 8'h00;
		end else if (wrOk) begin
			if (paddr == OFS_CMD) begin
				cmd_r <= clampPos(wVal, POS_MIN, POS_MAX);
			end else if (paddr == OFS_CUTOFF) begin
				cutoff_r <= wVal;
			end else if (paddr == OFS_SOFT_LO) begin
				softLo_r <= wVal;
			end else if (paddr == OFS_SOFT_HI) begin
				softHi_r <= wVal;
			end else if (paddr == OFS_TRAVEL_DB) begin
				travelDb_r <= wVal;
			end else if (paddr == OFS_STROKE) begin
				stroke_r <= pwdata[15:0];
			end else if (paddr == OFS_CYCLE_DB) begin
				cycleDb_r <= wVal;
			end else if (paddr == OFS_CYCLE_LIM && pstrb == 4'hF) begin
				cycleLim_r <= pwdata;
			end else if (paddr == OFS_DEV_TRIP) begin
				devTrip_r <= wVal;
			end else if (paddr == OFS_DEV_TIME && pstrb == 4'hF) begin
				devTime_r <= pwdata;
			end else if (paddr == OFS_MODE) begin
				mode_r <= vpl_mode_t'(pwdata[0]);
			end else if (paddr == OFS_FEATURES) begin
				features_r <= pwdata[7:0]; // R17
			end
		end
	end

	// Curve point storage
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < CURVE_PTS; i++) begin
				curve_x_points_r[i] <= 16'sh0000;
				curve_y_points_r[i] <= 16'sh0000;
			end
		end else if (accessWr && cHit && editOk) begin // R16
			if (cIsY) begin
				curve_y_points_r[cIdx] <= wVal; // R18
			end else begin
				curve_x_points_r[cIdx] <= wVal; // R18
			end
		end
	end

	// Refused edits are sticky; a new refusal wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			editRefused_r <= 1'b0;
		end else if (accessWr && cHit && !editOk) begin
			editRefused_r <= 1'b1; // R16
		end else if (accessWr && paddr == OFS_STATUS && pwdata[ST_EDIT_REFUSED]) begin
			editRefused_r <= 1'b0;
		end
	end

	// Tight shutoff saturation with hysteresis on the way out
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sat_r <= 1'b0;
		end else if (!cutoffEn) begin
			sat_r <= 1'b0; // R3 R4
		end else if (!sat_r && cmd_r <= cutoff_r) begin
			sat_r <= 1'b1; // R1
		end else if (sat_r && cmd_r >= cutoff_r + CUTOFF_HYST) begin
			sat_r <= 1'b0; // R2 R20
		end
	end

	// Drive output registered
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			drive_r <= '0;
		end else begin
			drive_r.saturate <= sat_r; // R1
			drive_r.target <= sat_r ? softLo_r : clampedCmd; // R1 R5
		end
	end
	assign drive = drive_r;

	// Travel accumulator with a moving dead-band
	logic signed [16:0] dbHi, dbLo, moveS;
	logic [15:0] moveAbs;
	logic [31:0] moveScaled;
	logic [32:0] travelSum;
	logic leaveDb;
	assign dbHi = 17'(center_r) + 17'(travelDb_r);
	assign dbLo = 17'(center_r) - 17'(travelDb_r);
	assign moveS = 17'(stemPos.value) - 17'(center_r);
	assign moveAbs = moveS[16] ? 16'(-moveS) : moveS[15:0];
	// Stroke length is used here only; calibration never sees it
	assign moveScaled = moveAbs * stroke_r; // R11 R12
	assign travelSum = 33'(travel_r) + 33'(moveScaled);
	assign leaveDb = (17'(stemPos.value) >= dbHi) || (17'(stemPos.value) <= dbLo); // R10
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			posSeen_r <= 1'b0;
			center_r <= 16'sh0000;
			travel_r <= 32'h0000_0000;
		end else if (stemPos.valid) begin
			posSeen_r <= 1'b1;
			if (!posSeen_r) begin
				center_r <= stemPos.value; // R7
			end else if (leaveDb) begin
				center_r <= stemPos.value; // R8
				travel_r <= travelSum[32] ? 32'hFFFF_FFFF : travelSum[31:0]; // R8 R21
			end
		end
	end

	// Cycle counter: follow the extreme, count a reversal beyond the dead-band
	logic signed [16:0] backOff;
	logic reversal;
	assign backOff = dirUp_r ? (17'(extreme_r) - 17'(stemPos.value))
		: (17'(stemPos.value) - 17'(extreme_r));
	assign reversal = posSeen_r && (backOff > 17'(cycleDb_r)); // R13
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			extreme_r <= 16'sh0000;
			dirUp_r <= 1'b1;
			cycles_r <= 32'h0000_0000;
		end else if (stemPos.valid) begin
			if (!posSeen_r) begin
				extreme_r <= stemPos.value;
			end else if (reversal) begin
				extreme_r <= stemPos.value;
				dirUp_r <= !dirUp_r;
				if (cycles_r != 32'hFFFF_FFFF) begin
					cycles_r <= cycles_r + 32'h0000_0001; // R13 R21
				end
			end else if (dirUp_r ? (stemPos.value > extreme_r) : (stemPos.value < extreme_r)) begin
				extreme_r <= stemPos.value;
			end
		end
	end
	assign cycleAlert = cycles_r > cycleLim_r; // R14

	// Position deviation timer
	logic signed [16:0] devS;
	logic [16:0] devAbs;
	assign devS = 17'(lastPos_r) - 17'(drive_r.target);
	assign devAbs = devS[16] ? 17'(-devS) : devS;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lastPos_r <= 16'sh0000;
		end else if (stemPos.valid) begin
			lastPos_r <= stemPos.value;
		end
	end
	// Saturated drive is excluded: the stem is meant to sit on the seat then
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			devCnt_r <= 32'h0000_0000;
		end else if (!posSeen_r || drive_r.saturate || devAbs <= 17'(devTrip_r)) begin
			devCnt_r <= 32'h0000_0000;
		end else if (devCnt_r <= devTime_r) begin
			devCnt_r <= devCnt_r + 32'h0000_0001; // R15
		end
	end
	assign devAlert = devCnt_r > devTime_r; // R15

	// Yellow indicator blinks while any alert stands
	logic blinkTick;
	assign blinkTick = (blinkCnt_r == 32'(BLINK_CYCLES - 1));
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			blinkCnt_r <= 32'h0000_0000;
		end else if (blinkTick) begin
			blinkCnt_r <= 32'h0000_0000;
		end else begin
			blinkCnt_r <= blinkCnt_r + 32'h0000_0001;
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			blink_r <= 1'b0;
		end else if (blinkTick) begin
			blink_r <= !blink_r;
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			yellowLed <= 1'b0;
		end else begin
			yellowLed <= blink_r && (limitHold || cycleAlert || devAlert); // R6 R14 R15
		end
	end
endmodule : vpl_position_limits
`default_nettype wire

// [src/vpl_pkg.sv]
// Constants, register map and carrier types of the valve position limits block
package vpl_pkg;
	// Positions are signed hundredths of a percent of stroke
	localparam int POS_W = 16;
	localparam logic signed [15:0] POS_FULL = 16'sh2710;
	localparam logic signed [15:0] POS_MIN = -16'sh03E8;
	localparam logic signed [15:0] POS_MAX = 16'sh2AF8;
	localparam logic signed [15:0] CUTOFF_HYST = 16'sh0064;
	// Register byte offsets
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_CUTOFF = 12'h004;
	localparam logic [11:0] OFS_SOFT_LO = 12'h008;
	localparam logic [11:0] OFS_SOFT_HI = 12'h00C;
	localparam logic [11:0] OFS_TRAVEL_DB = 12'h010;
	localparam logic [11:0] OFS_STROKE = 12'h014;
	localparam logic [11:0] OFS_TRAVEL = 12'h018;
	localparam logic [11:0] OFS_CYCLE_DB = 12'h01C;
	localparam logic [11:0] OFS_CYCLES = 12'h020;
	localparam logic [11:0] OFS_CYCLE_LIM = 12'h024;
	localparam logic [11:0] OFS_DEV_TRIP = 12'h028;
	localparam logic [11:0] OFS_DEV_TIME = 12'h02C;
	localparam logic [11:0] OFS_MODE = 12'h030;
	localparam logic [11:0] OFS_FEATURES = 12'h034;
	localparam logic [11:0] OFS_STATUS = 12'h038;
	localparam logic [11:0] OFS_CURVE_X = 12'h100;
	localparam logic [11:0] OFS_CURVE_Y = 12'h180;
	localparam int CURVE_PTS = 21;
	// Values after reset
	localparam logic signed [15:0] RST_CUTOFF = 16'sh01F4;
	localparam logic signed [15:0] RST_SOFT_LO = -16'sh03E8;
	localparam logic signed [15:0] RST_SOFT_HI = 16'sh2AF8;
	localparam logic signed [15:0] RST_TRAVEL_DB = 16'sh07D0;
	localparam logic [15:0] RST_STROKE = 16'h0004;
	localparam logic signed [15:0] RST_CYCLE_DB = 16'sh03E8;
	localparam logic [31:0] RST_CYCLE_LIM = 32'hFFFF_FFFF;
	localparam logic signed [15:0] RST_DEV_TRIP = 16'sh01F4;
	// Feature byte bit positions (position n sits at bit n-1)
	localparam int FEAT_QUICK_OPEN = 0;
	localparam int FEAT_EQUAL_PCT = 1;
	localparam int FEAT_ACT_TYPE = 2;
	localparam int FEAT_ADV_MODEL = 3;
	localparam int FEAT_ROTARY_GAIN = 4;
	localparam int FEAT_CUSTOM_CURVE = 5;
	localparam int FEAT_AIR_ACTION = 7;
	// Status bit positions
	localparam int ST_SATURATED = 0;
	localparam int ST_LIMIT_HOLD = 1;
	localparam int ST_CYCLE_ALERT = 2;
	localparam int ST_DEV_ALERT = 3;
	localparam int ST_EDIT_REFUSED = 4;
	localparam int ST_CURVE_ACTIVE = 5;
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int DEV_TIME_MS = 1000;
	localparam int DEV_TIME_CYC = CLK_HZ / 1000 * DEV_TIME_MS;

	typedef enum logic [0:0] {
		OPM_AUTO = 1'b0,
		OPM_OUT_OF_SERVICE = 1'b1
	} vpl_mode_t;

	typedef struct packed {
		logic valid;
		logic signed [15:0] value;
	} vpl_pos_t;

	typedef struct packed {
		logic saturate;
		logic signed [15:0] target;
	} vpl_drive_t;
endpackage : vpl_pkg

// [verification/vpl_limits_props.sv]
// Concurrent checks on the ports of the valve position limits block
`timescale 1ns/1ps
`default_nettype none
module vpl_limits_props
	import vpl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Stem, drive and indicator
	input wire vpl_pos_t stemPos,
	input wire vpl_drive_t drive,
	input wire logic yellowLed
);
	logic wr, crv, oos_r;
	logic [1:0] factory_r;
	logic signed [15:0] wv;
	assign wr = psel && penable && pwrite;
	assign crv = wr && paddr >= OFS_CURVE_X && paddr <= 12'h1D0;
	assign wv = pwdata[15:0];
	// Shadows of the mode and factory flags, which gate every curve edit
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			oos_r <= 1'h0;
		else if (wr && paddr == OFS_MODE && pstrb[1:0] == 2'h3)
			oos_r <= pwdata[0];
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			factory_r <= 2'h0;
		else if (wr && paddr == OFS_FEATURES && pstrb[1:0] == 2'h3)
			factory_r <= pwdata[1:0];
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence setupThenAccess;
		psel && !penable ##1 psel && penable;
	endsequence
	apb_no_wait_a: assert property (setupThenAccess |-> pready)
		else $error("pready low in access phase");
	err_in_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	unmapped_err_a: assert property (psel && penable && paddr == 12'h03C |-> pslverr)
		else $error("unmapped access not refused");
	edit_in_auto_a: assert property (crv && !oos_r |-> pslverr)
		else $error("curve edit taken in automatic mode");
	curve_range_a: assert property (crv && (wv > POS_MAX || wv < POS_MIN) |-> pslverr)
		else $error("curve value out of range taken");
	factory_flag_a: assert property (crv && factory_r != 2'h0 |-> pslverr)
		else $error("curve edit taken with factory curve selected");
	// The startup settling of saturation after reset is excluded by the depth guard
	target_cause_a: assert property ($past(resetn, 4) && $changed(drive.target) |->
		$past(wr, 2) || $past(wr, 3)) else $error("target moved without a write");
	sat_cause_a: assert property ($past(resetn, 4) && $changed(drive.saturate) |->
		$past(wr, 3)) else $error("saturation changed without a write");
endmodule : vpl_limits_props
bind vpl_position_limits vpl_limits_props u_vpl_limits_props (.sys_clk, .resetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .stemPos,
	.drive, .yellowLed);
`default_nettype wire

// [verification/vpl_stem_model.sv]
// Stem position sensor model that samples the actuator drive
`timescale 1ns/1ps
`default_nettype none
module vpl_stem_model
	import vpl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Actuator drive and bench control
	input wire vpl_drive_t drive,
	input wire logic pin,
	input wire logic signed [15:0] pinPos,
	input wire logic [3:0] gap,
	// Feedback
	output var vpl_pos_t stemPos
);
	logic [3:0] cnt_r;
	// Between samples the value is scrambled so a stale reading is never trusted
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 4'h0;
			stemPos <= '0;
		end else if (cnt_r >= gap) begin
			cnt_r <= 4'h0;
			stemPos.valid <= 1'h1;
			stemPos.value <= pin ? pinPos : drive.target;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			stemPos.valid <= 1'h0;
			stemPos.value <= ~stemPos.value;
		end
	end
endmodule : vpl_stem_model
`default_nettype wire

// [verification/test_valve_position_limits_and_travel.sv]
// Self-checking bench for the valve position limits block
`timescale 1ns/1ps
`default_nettype none
module test_valve_position_limits_and_travel
	import vpl_pkg::*;
;
	logic sys_clk, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pin = 1'h1;
	logic sat, err, pready, pslverr, yellowLed, ledPrev;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, trav, stroke, lfsr = 32'h89f7;
	logic [3:0] pstrb = 4'hF, gap = 4'h3;
	logic signed [15:0] pinPos = 16'sh1388, cen;
	vpl_pos_t stemPos;
	vpl_drive_t drive;
	int mismatches = 0, compares = 0, cyc = 0, tog;
	logic [11:0] rstOfs [5] = '{OFS_CUTOFF, OFS_SOFT_LO, OFS_TRAVEL_DB, OFS_STROKE, OFS_CYCLE_LIM};
	logic [31:0] rstVal [5] = '{32'h0000_01F4, 32'h0000_FC18, 32'h0000_07D0, 32'h0000_0004,
		32'hFFFF_FFFF};
	logic signed [15:0] cutCmd [8] = '{16'sh1388, 16'sh01F4, 16'sh012C, 16'sh0257, 16'sh0258,
		16'sh01F5, 16'sh01F4, 16'sh1388};
	logic [11:0] cAdr [5] = '{12'h100, 12'h104, 12'h104, 12'h104, 12'h180};
	logic [15:0] cVal [5] = '{16'h0000, 16'hFFFF, 16'h2AF9, 16'h2AF8, 16'hFC18};
	logic cErr [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
	logic signed [15:0] mPos [5] = '{16'sh1770, 16'sh0BB8, 16'sh1F40, 16'sh0000, 16'sh2710};
	vpl_position_limits #(.BLINK_CYCLES(4), .DEV_TIME_RST(8)) u_vpl_position_limits (.sys_clk,
		.resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.stemPos, .drive, .yellowLed);
	vpl_stem_model u_vpl_stem_model (.sys_clk, .resetn, .drive, .pin, .pinPos, .gap, .stemPos);
	initial begin
		sys_clk = 1'h0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// A hang anywhere ends here as a failure
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRand
	function automatic logic signed [15:0] clampT(input logic signed [15:0] c, lo, hi);
		return c < lo ? lo : (c > hi ? hi : c);
	endfunction : clampT
	function automatic logic expSat(input logic s, input logic signed [15:0] c, lo, hi);
		if (lo > 16'sh0000 || hi < POS_FULL)
			return 1'h0;
		return s ? c < RST_CUTOFF + CUTOFF_HYST : c <= RST_CUTOFF;
	endfunction : expSat
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rst(input logic signed [15:0] p);
		resetn <= 1'h0;
		pin <= 1'h1;
		pinPos <= p;
		cen = p;
		trav = '0;
		stroke = 32'h0000_0004;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'h1;
		// The first sample after reset centres the dead-band, so let it land at p
		do @(posedge sys_clk); while (stemPos.valid !== 1'h1);
	endtask : rst
	task automatic cmdCase(input logic signed [15:0] lo, hi, c);
		apb(1'h1, OFS_SOFT_LO, 32'(lo));
		apb(1'h1, OFS_SOFT_HI, 32'(hi));
		apb(1'h1, OFS_CMD, 32'(c));
		sat = expSat(sat, c, lo, hi);
		repeat (4) @(posedge sys_clk);
		chk("saturate", 32'(sat), 32'(drive.saturate));
		chk("target", 32'(sat ? lo : clampT(c, lo, hi)), 32'(drive.target));
	endtask : cmdCase
	task automatic moveTo(input logic signed [15:0] p);
		pinPos <= p;
		do @(posedge sys_clk); while (!(stemPos.valid === 1'h1 && stemPos.value === p));
		if (p >= cen + RST_TRAVEL_DB || p <= cen - RST_TRAVEL_DB) begin
			trav += 32'(p > cen ? p - cen : cen - p) * stroke;
			cen = p;
		end
		apb(1'h0, OFS_TRAVEL, '0);
		chk("travel", trav, rd);
	endtask : moveTo
	initial begin
		rst(16'sh1388);
		pin <= 1'h0;
		foreach (rstOfs[i]) begin
			apb(1'h0, rstOfs[i], '0);
			chk("resetValue", rstVal[i], rd);
		end
		sat = 1'h1;
		foreach (cutCmd[i])
			cmdCase(RST_SOFT_LO, RST_SOFT_HI, cutCmd[i]);
		repeat (10) begin
			lfsr = nextRand(lfsr);
			cmdCase(16'sh03E8, 16'sh2328, 16'(lfsr % 32'h0000_2EE1) - 16'sh03E8);
		end
		cmdCase(16'sh03E8, 16'sh2328, 16'sh251C);
		tog = 0;
		ledPrev = yellowLed;
		repeat (12) begin
			@(posedge sys_clk);
			if (yellowLed !== ledPrev)
				tog++;
			ledPrev = yellowLed;
		end
		chk("ledToggles", 1, 32'(tog >= 2));
		cmdCase(RST_SOFT_LO, 16'sh2328, 16'sh0000);
		cmdCase(16'sh0000, RST_SOFT_HI, 16'sh0064);
		apb(1'h0, 12'h03C, '0);
		chk("unmappedErr", 1, err);
		apb(1'h1, OFS_CURVE_X, '0);
		chk("autoEditErr", 1, err);
		apb(1'h0, OFS_STATUS, '0);
		chk("editRefused", 1, rd[ST_EDIT_REFUSED]);
		apb(1'h1, OFS_MODE, 32'h0000_0001);
		foreach (cAdr[i]) begin
			apb(1'h1, cAdr[i], {16'h0000, cVal[i]});
			chk("curveErr", cErr[i], err);
		end
		apb(1'h0, 12'h104, '0);
		chk("curvePoint", 32'h0000_2AF8, rd);
		apb(1'h1, OFS_FEATURES, 32'h0000_0001);
		apb(1'h1, 12'h108, 32'h0000_2AF8);
		chk("factoryFlagErr", 1, err);
		apb(1'h1, OFS_FEATURES, 32'h0000_0020);
		apb(1'h0, OFS_STATUS, '0);
		chk("curveActive", 1, rd[ST_CURVE_ACTIVE]);
		rst(16'sh1388);
		apb(1'h1, OFS_CYCLE_LIM, 32'h0000_0003);
		foreach (mPos[i]) begin
			if (i == 3) begin
				stroke = 32'h0000_005A;
				apb(1'h1, OFS_STROKE, stroke);
			end
			moveTo(mPos[i]);
			apb(1'h0, OFS_CYCLES, '0);
			chk("cycles", 32'(i), rd);
			apb(1'h0, OFS_STATUS, '0);
			chk("cycleAlert", 32'(i > 3), 32'(rd[ST_CYCLE_ALERT]));
		end
		rst(16'sh1388);
		gap <= 4'h9;
		apb(1'h1, OFS_CMD, 32'h0000_1388);
		moveTo(16'sh1F40);
		apb(1'h0, OFS_STATUS, '0);
		chk("devEarly", 0, rd[ST_DEV_ALERT]);
		repeat (10) @(posedge sys_clk);
		apb(1'h0, OFS_STATUS, '0);
		chk("devAlert", 1, rd[ST_DEV_ALERT]);
		test_done();
	end
endmodule : test_valve_position_limits_and_travel
`default_nettype wire
